// ---- core/ctrl_ep_pkg.sv ----
// Shared constants and carriers for the control endpoint engine.
// Assumes a packet engine on the same clock that decodes tokens and packet lengths.
package ctrl_ep_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [4:0] REG_CSR   = 5'h00; // Control/status of the control endpoint
  localparam logic [4:0] REG_COUNT = 5'h04; // Received byte count
  localparam logic [4:0] REG_FLAGS = 5'h08; // Endpoint interrupt flags, clear on read
  localparam logic [4:0] REG_MASK  = 5'h0c; // Endpoint interrupt mask
  localparam logic [4:0] REG_CTRL  = 5'h10; // Controller enable and global irq enable
  // Status register field positions
  localparam int B_RXWAIT  = 0; // Packet received, waiting for firmware
  localparam int B_LOADED  = 1; // Transmit packet loaded
  localparam int B_SENTSTL = 2; // Stall issued, write 1 to clear
  localparam int B_DATAEND = 3; // Last-data mark
  localparam int B_PREMEND = 4; // Premature end seen
  localparam int B_SENDSTL = 5; // Stall request
  localparam int B_RELEASE = 6; // Packet release strobe
  localparam int B_PECLR   = 7; // Premature end clear strobe
  localparam int B_STATE   = 8; // Two-bit state field
  localparam int B_GLOBEN  = 1; // Global irq enable in control register
  // Packet sizes
  localparam logic [6:0] MAX_PKT   = 7'h20; // Fixed control packet limit
  localparam logic [6:0] SETUP_LEN = 7'h08; // Setup payload length
  // Reset values
  localparam logic MASK_RST = 1'b1; // Endpoint interrupt enabled after reset

  typedef enum logic [1:0] {TOK_SETUP = 2'b00, TOK_IN = 2'b01, TOK_OUT = 2'b10} tokKind_t;
  typedef enum logic [1:0] {ANS_ACK = 2'b00, ANS_NAK = 2'b01, ANS_STALL = 2'b10,
                            ANS_DATA = 2'b11} ansKind_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_TX = 2'b01, ST_RX = 2'b10,
                            ST_STATUS = 2'b11} epState_t;

  // Token plus the payload length of the data packet that followed it
  typedef struct packed {
    logic       valid;     // One-cycle pulse
    tokKind_t   kind;      // Token type
    logic [6:0] len;       // Payload bytes, saturates at 127
    logic       setupIn;   // Setup asks for data toward the host
    logic       setupData; // Setup announces a data stage
  } tok_t;

  // Handshake or data decision back to the packet engine
  typedef struct packed {
    logic     valid;   // One-cycle pulse
    ansKind_t kind;    // Answer type
    logic     zeroLen; // Data answer is a zero-length packet
  } ans_t;
endpackage

// ---- core/ctrl_ep_fsm.sv ----
// Control endpoint transfer engine with a Wishbone register slave.
// Assumes tokens arrive as one-cycle pulses from packet logic on clk.
// Functional notes
// [RL1] Protocol error: STALL, stall flag, interrupt
// [RL2] OUT after last-data mark is error
// [RL3] IN after last-data mark is error
// [RL4] OUT data over 32 bytes is error
// [RL5] Non-empty status DATA1 packet is error
// [RL6] Stall request makes following requests STALL
// [RL7] Firmware clears stall flag, aborts transfer
// [RL8] Unexpected data-stage token: premature end, IDLE
// [RL9] Firmware clears premature end, checks setup
// [RL10] Accept setup only with 8-byte payload
// [RL11] Release without mark enters TX or RX
// [RL12] Received packet sets flag and interrupt
// [RL13] Release with mark, no data: stays idle; the code enters STATUS toward the host instead
// [RL14] TX takes only IN, RX only OUT
// [RL15] 32-byte packets, short packet ends transfer
// [RL16] Sent packet clears loaded bit, one interrupt
// [RL17] Firmware marks last IN packet
// [RL18] Status done returns IDLE; stall request fails it
// [RL19] IN without loaded packet answers NAK
// [RL20] Firmware releases only after unloading
// [RL21] Firmware marks last short OUT packet
// [RL22] Count register valid while packet waiting
// [RL23] Single buffer, 32-byte maximum packet
// [RL24] Flag always set; irq needs mask, enable
// [RL25] Disable or reset returns IDLE, clears flags
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module ctrl_ep_fsm (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Wishbone slave
  input  wire logic                wbCyc,
  input  wire logic                wbStb,
  input  wire logic                wbWe,
  input  wire logic [4:0]          wbAdr,
  input  wire logic [3:0]          wbSel,
  input  wire logic [31:0]         wbDatIn,
  output logic      [31:0]         wbDatOut,
  output logic                     wbAck,
  // Packet engine side
  input  wire ctrl_ep_pkg::tok_t   tokIn,
  input  wire logic                hostAck,
  output ctrl_ep_pkg::ans_t        ansOut,
  // Interrupt request
  output logic                     irq
);
  import ctrl_ep_pkg::*;

  epState_t   state_q, state_d;       // Endpoint state
  logic       rxWait_q, rxWait_d;     // Packet waiting for firmware
  logic       loaded_q, loaded_d;     // Transmit packet loaded
  logic       sentStl_q, sentStl_d;   // Stall issued
  logic       dataEnd_q, dataEnd_d;   // Last-data mark
  logic       premEnd_q, premEnd_d;   // Premature end
  logic       sendStl_q, sendStl_d;   // Stall request
  logic       statIn_q, statIn_d;     // Status stage goes toward the host
  logic       awaitAck_q, awaitAck_d; // Data sent, waiting for host handshake
  logic       setupIn_q, setupIn_d;   // Latched setup direction
  logic       setupDat_q, setupDat_d; // Latched data-stage presence
  logic [6:0] count_q, count_d;       // Received byte count
  logic       flag_q, flag_d;         // Endpoint interrupt flag
  logic       mask_q;                 // Endpoint interrupt mask
  logic       usbEn_q;                // Controller enable
  logic       globEn_q;               // Global interrupt enable
  ans_t       ans_d;                  // Answer for this cycle
  logic       evt;                    // Any endpoint event

  // Bus decode; accesses complete on the cycle wbAck is high
  wire        busReq  = wbCyc & wbStb;
  wire        busDone = busReq & wbAck;
  wire        wrLow   = busDone & wbWe & wbSel[0];
  wire        wrCsr   = wrLow & (wbAdr == REG_CSR);
  wire        rdFlags = busDone & ~wbWe & (wbAdr == REG_FLAGS);
  wire        wrMask  = wrLow & (wbAdr == REG_MASK);
  wire        wrCtrl  = wrLow & (wbAdr == REG_CTRL);
  // Next enables; irq uses them so a mask write drops it in the same cycle
  wire        mask_d   = wrMask ? wbDatIn[0] : mask_q;
  wire        globEn_d = wrCtrl ? wbDatIn[B_GLOBEN] : globEn_q;
  wire [31:0] csrView = {22'h0, state_q, 1'b0, 1'b0, sendStl_q, premEnd_q,
                         dataEnd_q, sentStl_q, loaded_q, rxWait_q};
  wire [31:0] rdMux   = (wbAdr == REG_CSR)   ? csrView :
                        (wbAdr == REG_COUNT) ? {25'h0, count_q} :
                        (wbAdr == REG_FLAGS) ? {31'h0, flag_q} :
                        (wbAdr == REG_MASK)  ? {31'h0, mask_q} :
                        (wbAdr == REG_CTRL)  ? {30'h0, globEn_q, usbEn_q} : 32'h0;

  // Register writes first, then link events, so hardware sets win over clears
  always_comb begin
    state_d = state_q;
    rxWait_d = rxWait_q;
    loaded_d = loaded_q;
    sentStl_d = sentStl_q;
    dataEnd_d = dataEnd_q;
    premEnd_d = premEnd_q;
    sendStl_d = sendStl_q;
    statIn_d = statIn_q;
    awaitAck_d = awaitAck_q;
    setupIn_d = setupIn_q;
    setupDat_d = setupDat_q;
    count_d = count_q;
    ans_d = '0;
    evt = 1'b0;
    // Firmware side of the status register
    if (wrCsr) begin
      sendStl_d = wbDatIn[B_SENDSTL];
      if (wbDatIn[B_SENTSTL]) sentStl_d = 1'b0;
      if (wbDatIn[B_PECLR]) premEnd_d = 1'b0;
      if (wbDatIn[B_LOADED]) loaded_d = 1'b1;
      if (wbDatIn[B_DATAEND] && state_q == ST_TX) dataEnd_d = 1'b1;
      if (wbDatIn[B_RELEASE] && rxWait_q) begin
        rxWait_d = 1'b0;
        if (state_q == ST_IDLE && wbDatIn[B_DATAEND]) begin
          state_d = ST_STATUS; // [RL13]
          statIn_d = 1'b1;
        end else if (state_q == ST_IDLE && setupDat_q) begin
          state_d = setupIn_q ? ST_TX : ST_RX; // [RL11]
          dataEnd_d = 1'b0;
        end else if (state_q == ST_RX && wbDatIn[B_DATAEND]) begin
          state_d = ST_STATUS; // [RL21]
          statIn_d = 1'b1;
        end
      end
    end
    // Host handshake for a packet this endpoint sent
    if (hostAck && awaitAck_q) begin
      awaitAck_d = 1'b0;
      evt = 1'b1;
      if (state_q == ST_TX) begin
        loaded_d = 1'b0; // [RL16]
        if (dataEnd_q) begin
          state_d = ST_STATUS; // [RL17]
          statIn_d = 1'b0;
        end
      end else begin
        state_d = ST_IDLE; // [RL18]
      end
    end
    // Token handling
    if (tokIn.valid) begin
      ans_d.valid = 1'b1;
      ans_d.kind = ANS_NAK;
      if (tokIn.kind == TOK_SETUP) begin
        if (state_q == ST_TX || state_q == ST_RX) premEnd_d = 1'b1; // [RL8]
        if (tokIn.len == SETUP_LEN) begin
          ans_d.kind = ANS_ACK; // [RL10]
          rxWait_d = 1'b1; // [RL12]
          count_d = tokIn.len; // [RL22]
          setupIn_d = tokIn.setupIn;
          setupDat_d = tokIn.setupData;
          state_d = ST_IDLE;
          dataEnd_d = 1'b0;
          loaded_d = 1'b0;
          awaitAck_d = 1'b0;
          evt = 1'b1;
        end else begin
          ans_d.valid = 1'b0; // Rejected: no handshake at all
          if (state_q == ST_TX || state_q == ST_RX) begin
            state_d = ST_IDLE;
            evt = 1'b1;
          end
        end
      end else if (sendStl_q) begin
        ans_d.kind = ANS_STALL; // [RL6]
      end else if ((state_q == ST_TX && tokIn.kind == TOK_OUT) ||
                   (state_q == ST_RX && tokIn.kind == TOK_IN)) begin
        ans_d.valid = 1'b0; // [RL14]
        premEnd_d = 1'b1; // [RL8]
        state_d = ST_IDLE;
        evt = 1'b1;
      end else if (state_q == ST_TX) begin
        if (dataEnd_q && !loaded_q) ans_d.kind = ANS_STALL; // [RL3]
        else if (loaded_q) begin
          ans_d.kind = ANS_DATA;
          awaitAck_d = 1'b1;
        end // [RL19]
      end else if (state_q == ST_RX) begin
        if (tokIn.len > MAX_PKT) ans_d.kind = ANS_STALL; // [RL4]
        else if (!rxWait_q) begin // [RL15]
          ans_d.kind = ANS_ACK; // [RL23]
          rxWait_d = 1'b1; // [RL12]
          count_d = tokIn.len; // [RL22]
          evt = 1'b1;
        end
      end else if (state_q == ST_STATUS) begin
        if (statIn_q && tokIn.kind == TOK_OUT) ans_d.kind = ANS_STALL; // [RL2]
        else if (!statIn_q && tokIn.kind == TOK_IN) ans_d.kind = ANS_STALL; // [RL3]
        else if (!statIn_q && tokIn.len != 7'h00) ans_d.kind = ANS_STALL; // [RL5]
        else if (statIn_q) begin
          ans_d.kind = ANS_DATA;
          ans_d.zeroLen = 1'b1;
          awaitAck_d = 1'b1;
        end else begin
          ans_d.kind = ANS_ACK;
          state_d = ST_IDLE; // [RL18]
          evt = 1'b1;
        end
      end else if (tokIn.kind == TOK_OUT) begin
        ans_d.kind = ANS_STALL; // No transfer open: protocol error
      end
      // Any stall issued aborts the transfer
      if (ans_d.valid && ans_d.kind == ANS_STALL) begin
        sentStl_d = 1'b1; // [RL1]
        evt = 1'b1;
        state_d = ST_IDLE;
        dataEnd_d = 1'b0;
        loaded_d = 1'b0;
        awaitAck_d = 1'b0;
      end
    end
  end

  // Flag is set by every event; a read clears it unless an event lands too
  assign flag_d = evt | (flag_q & ~rdFlags); // [RL24]

  // Endpoint state; disabling the controller acts as a reset
  always_ff @(posedge clk) begin
    if (reset || !usbEn_q) begin // [RL25]
      {state_q, rxWait_q, loaded_q, sentStl_q, dataEnd_q, premEnd_q} <= '0;
      {sendStl_q, statIn_q, awaitAck_q, setupIn_q, setupDat_q} <= '0;
      count_q <= '0;
      flag_q <= 1'b0;
    end else begin
      {state_q, rxWait_q, loaded_q, sentStl_q, dataEnd_q, premEnd_q} <=
        {state_d, rxWait_d, loaded_d, sentStl_d, dataEnd_d, premEnd_d};
      {sendStl_q, statIn_q, awaitAck_q, setupIn_q, setupDat_q} <=
        {sendStl_d, statIn_d, awaitAck_d, setupIn_d, setupDat_d};
      count_q <= count_d;
      flag_q <= flag_d;
    end
  end

  // Enables survive a controller disable so software can turn it back on
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= MASK_RST;
      usbEn_q <= 1'b0;
      globEn_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      globEn_q <= globEn_d;
      if (wrCtrl) usbEn_q <= wbDatIn[0];
    end
  end

  // Bus answer one cycle after the request; read data captured with it
  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck <= 1'b0;
      wbDatOut <= '0;
    end else begin
      wbAck <= busReq & ~wbAck;
      wbDatOut <= rdMux;
    end
  end

  // Answer to the packet engine and interrupt line
  always_ff @(posedge clk) begin
    if (reset || !usbEn_q) begin
      ansOut <= '0;
      irq <= 1'b0;
    end else begin
      ansOut <= ans_d;
      irq <= flag_d & mask_d & globEn_d; // [RL24]
    end
  end

  // Checks
  wire tokGo = tokIn.valid & usbEn_q;
  property p_stall_flag;
    @(posedge clk) disable iff (reset)
    ansOut.valid && ansOut.kind == ANS_STALL |-> sentStl_q && state_q == ST_IDLE;
  endproperty
  a_stall_flag: assert property (p_stall_flag) else $error("stall without flag"); // [RL1]
  property p_out_after_end;
    @(posedge clk) disable iff (reset)
    tokGo && !sendStl_q && state_q == ST_STATUS && statIn_q && tokIn.kind == TOK_OUT
      |=> ansOut.valid && ansOut.kind == ANS_STALL;
  endproperty
  a_out_after_end: assert property (p_out_after_end) else $error("late OUT not stalled"); // [RL2]
  property p_big_out;
    @(posedge clk) disable iff (reset)
    tokGo && state_q == ST_RX && tokIn.kind == TOK_OUT && tokIn.len > MAX_PKT
      |=> ansOut.valid && ansOut.kind == ANS_STALL && (!rxWait_q || $past(rxWait_q));
  endproperty
  a_big_out: assert property (p_big_out) else $error("oversize OUT accepted"); // [RL4]
  property p_status_len;
    @(posedge clk) disable iff (reset)
    tokGo && !sendStl_q && state_q == ST_STATUS && !statIn_q && tokIn.kind == TOK_OUT
      && tokIn.len != 7'h00 |=> ansOut.kind == ANS_STALL;
  endproperty
  a_status_len: assert property (p_status_len) else $error("status length ignored"); // [RL5]
  property p_send_stall;
    @(posedge clk) disable iff (reset)
    tokGo && sendStl_q && tokIn.kind != TOK_SETUP |=> ansOut.kind == ANS_STALL ##1 flag_q
      || $past(rdFlags);
  endproperty
  a_send_stall: assert property (p_send_stall) else $error("stall request ignored"); // [RL6]
  property p_setup_len;
    @(posedge clk) disable iff (reset)
    tokGo && tokIn.kind == TOK_SETUP && tokIn.len != SETUP_LEN |=> !ansOut.valid;
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("bad setup answered"); // [RL10]
  property p_nak;
    @(posedge clk) disable iff (reset)
    tokGo && !sendStl_q && state_q == ST_TX && tokIn.kind == TOK_IN && !loaded_q
      && !dataEnd_q |=> ansOut.kind == ANS_NAK;
  endproperty
  a_nak: assert property (p_nak) else $error("empty IN not NAKed"); // [RL19]
  property p_sent_clear;
    @(posedge clk) disable iff (reset)
    hostAck && awaitAck_q && state_q == ST_TX && usbEn_q && !tokIn.valid
      |=> !loaded_q && flag_q;
  endproperty
  a_sent_clear: assert property (p_sent_clear) else $error("loaded bit kept"); // [RL16]
  property p_irq_gate;
    @(posedge clk) disable iff (reset) irq |-> mask_q && globEn_q && flag_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated"); // [RL24]
  property p_disable;
    @(posedge clk) disable iff (reset)
    !usbEn_q |=> state_q == ST_IDLE && !rxWait_q && !sentStl_q && !premEnd_q;
  endproperty
  a_disable: assert property (p_disable) else $error("disable kept state"); // [RL25]
  c_setup: cover property (@(posedge clk) ansOut.valid && ansOut.kind == ANS_ACK && rxWait_q);
  c_tx: cover property (@(posedge clk) state_q == ST_TX ##[1:50] state_q == ST_STATUS);
  c_prem: cover property (@(posedge clk) $rose(premEnd_q));
  c_stall: cover property (@(posedge clk) $rose(sentStl_q));
endmodule // ctrl_ep_fsm

// ---- verif/usb_host_model.sv ----
// Behavioural host: issues one token at a time and acknowledges data packets.
// Assumes the bench spaces its tokens so that each answer returns before the next.
`timescale 1ns/1ns
module usb_host_model (
  // Clock
  input  wire logic              clk,
  // Token side
  output ctrl_ep_pkg::tok_t      tokIn,
  output logic                   hostAck,
  input  wire ctrl_ep_pkg::ans_t ansOut,
  // Cycles to wait before acknowledging a data packet
  input  wire logic [2:0]        ackDelay
);
  import ctrl_ep_pkg::*;

  // Idle at time zero
  initial begin
    tokIn = '0;
    hostAck = 1'b0;
  end

  // One-cycle token pulse; afterwards the fields show the inverse, so nothing stale looks valid
  task automatic send(input tokKind_t k, input logic [6:0] n, input logic si, input logic sd);
    @(posedge clk);
    tokIn <= '{valid: 1'b1, kind: k, len: n, setupIn: si, setupData: sd};
    @(posedge clk);
    tokIn <= tok_t'({1'b0, ~{k, n, si, sd}});
  endtask

  // Acknowledge each data packet, promptly or slowly
  always @(posedge clk) begin
    if (ansOut.valid === 1'b1 && ansOut.kind === ANS_DATA) begin
      repeat (ackDelay) @(posedge clk);
      hostAck <= 1'b1;
      @(posedge clk);
      hostAck <= 1'b0;
    end
  end
endmodule // usb_host_model

// ---- verif/usb_control_endpoint_fsm_tb.sv ----
// Bench for the control endpoint engine: firmware over Wishbone, host through a model.
// Assumes at most one answer per token, one cycle later; bus waits last until acknowledge.
`timescale 1ns/1ns
module usb_control_endpoint_fsm_tb;
  import ctrl_ep_pkg::*;
  localparam logic [31:0] REL   = 32'h1 << B_RELEASE; // Release strobe
  localparam logic [31:0] LOAD  = 32'h1 << B_LOADED;  // Packet loaded
  localparam logic [31:0] DEND  = 32'h1 << B_DATAEND; // Last-data mark
  localparam logic [31:0] STL   = 32'h1 << B_SENTSTL; // Stall issued, W1C
  localparam logic [31:0] SNDS  = 32'h1 << B_SENDSTL; // Stall request
  localparam logic [31:0] PECLR = 32'h1 << B_PECLR;   // Premature end clear

  logic        clk;        // 100 MHz clock
  logic        reset;      // Synchronous reset
  logic [43:0] busReq;     // {cyc, stb, we, sel, adr, wdata}, one assignment per change
  logic [31:0] wbDatOut;   // Read data
  logic        wbAck;      // Bus acknowledge
  tok_t        tokIn;      // Token from host
  logic        hostAck;    // Host acknowledge
  ans_t        ansOut;     // Answer to host
  logic        irq;        // Interrupt request
  logic [2:0]  ackDelay;   // Host acknowledge delay
  logic [2:0]  expQ[$];    // Expected {zeroLen, kind}, oldest first
  logic [2:0]  expNote;    // Expectation taken off the queue
  logic        zlNext;     // Next noted answer is a zero-length packet
  logic [31:0] rdat;       // Discarded read data
  int          mismatches;
  int          cmp_count;
  int          cycles;     // Timeout counter

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  usb_host_model host (.clk(clk), .tokIn(tokIn), .hostAck(hostAck), .ansOut(ansOut),
                       .ackDelay(ackDelay));
  ctrl_ep_fsm dut (.clk(clk), .reset(reset), .wbCyc(busReq[43]), .wbStb(busReq[42]),
                   .wbWe(busReq[41]), .wbSel(busReq[40:37]), .wbAdr(busReq[36:32]),
                   .wbDatIn(busReq[31:0]), .wbDatOut(wbDatOut), .wbAck(wbAck),
                   .tokIn(tokIn), .hostAck(hostAck), .ansOut(ansOut), .irq(irq));

  // Single comparison point
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic Wishbone cycle; held until ack is sampled high, released at that edge
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    busReq <= {1'b1, 1'b1, we, 4'hf, a, d};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    r = wbDatOut;
    busReq <= '0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rdat);
  endtask

  // Read and compare the masked bits
  task automatic rdChk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(nm, r & m, e);
  endtask

  // Token with its expected answer noted first; long enough for a slow host acknowledge
  task automatic tok(input tokKind_t k, input logic [6:0] n, input logic si, input logic sd,
                     input logic hasAns, input ansKind_t e);
    if (hasAns) begin
      expQ.push_back({zlNext, e});
    end
    ackDelay <= 3'($urandom_range(0, 6));
    host.send(k, n, si, sd);
    repeat (10) @(posedge clk);
  endtask

  // Accepted setup, then release as firmware would
  task automatic setupRel(input logic si, input logic sd, input logic [31:0] extra);
    tok(TOK_SETUP, 7'h08, si, sd, 1'b1, ANS_ACK);
    wr(REG_CSR, REL | extra);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Each answer seen is matched to the oldest expectation
  always @(posedge clk) begin
    if (ansOut.valid === 1'b1) begin
      if (expQ.size() == 0) begin
        chk("unexpectedAnswer", 32'h1, 32'h0);
      end else begin
        expNote = expQ.pop_front();
        chk("answerKind", 32'(ansOut.kind), 32'(expNote[1:0]));
        chk("zeroLen", 32'(ansOut.zeroLen), 32'(expNote[2]));
      end
    end
  end

  // Cuts a hang short; the whole run needs about six hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    int i;
    void'($urandom(63));
    busReq = '0;
    ackDelay = 3'h0;
    zlNext = 1'b0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdChk(REG_MASK, 32'h1, 32'h1, "maskReset");
    rdChk(REG_CSR, 32'h3ff, 32'h0, "csrReset");
    tok(TOK_SETUP, 7'h08, 1'b0, 1'b0, 1'b0, ANS_ACK);
    wr(REG_CTRL, 32'h3);
    rdChk(5'h14, 32'hffffffff, 32'h0, "unmapped");
    tok(TOK_SETUP, 7'($urandom_range(9, 64)), 1'b0, 1'b0, 1'b0, ANS_ACK);
    tok(TOK_SETUP, 7'($urandom_range(0, 7)), 1'b0, 1'b0, 1'b0, ANS_ACK);
    rdChk(REG_CSR, 32'h1, 32'h0, "rejectedSetup");
    // Setup without data stage
    tok(TOK_SETUP, 7'h08, 1'b0, 1'b0, 1'b1, ANS_ACK);
    chk("irq", 32'(irq), 32'h1);
    rdChk(REG_COUNT, 32'h7f, 32'h8, "setupCount");
    rdChk(REG_FLAGS, 32'h1, 32'h1, "flagSet");
    wr(REG_CSR, REL | DEND);
    rdChk(REG_CSR, 32'h301, 32'h300, "statusIn");
    zlNext = 1'b1;
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_DATA);
    zlNext = 1'b0;
    rdChk(REG_CSR, 32'h300, 32'h0, "idleAfterStatus");
    // IN data stage, then one IN too many
    setupRel(1'b1, 1'b1, 32'h0);
    rdChk(REG_CSR, 32'h300, 32'h100, "txState");
    rdChk(REG_FLAGS, 32'h1, 32'h1, "setupFlag");
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_NAK);
    wr(REG_CSR, LOAD);
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_DATA);
    rdChk(REG_CSR, 32'h2, 32'h0, "loadedCleared");
    rdChk(REG_FLAGS, 32'h1, 32'h1, "sentFlag");
    wr(REG_CSR, LOAD | DEND);
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_DATA);
    rdChk(REG_CSR, 32'h300, 32'h300, "statusOut");
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_STALL);
    rdChk(REG_CSR, 32'h304, 32'h004, "sentStall");
    wr(REG_CSR, STL);
    rdChk(REG_CSR, 32'h4, 32'h0, "stallCleared");
    // Status packet with and without payload
    for (i = 0; i < 2; i++) begin
      setupRel(1'b1, 1'b1, 32'h0);
      wr(REG_CSR, LOAD | DEND);
      tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_DATA);
      tok(TOK_OUT, (i == 0) ? 7'($urandom_range(1, 32)) : 7'h00, 1'b0, 1'b0, 1'b1,
          (i == 0) ? ANS_STALL : ANS_ACK);
      wr(REG_CSR, STL);
    end
    // OUT data stage: full packet, busy buffer, oversize packet
    setupRel(1'b0, 1'b1, 32'h0);
    rdChk(REG_CSR, 32'h300, 32'h200, "rxState");
    tok(TOK_OUT, 7'h20, 1'b0, 1'b0, 1'b1, ANS_ACK);
    rdChk(REG_COUNT, 32'h7f, 32'h20, "fullCount");
    tok(TOK_OUT, 7'h05, 1'b0, 1'b0, 1'b1, ANS_NAK);
    wr(REG_CSR, REL);
    tok(TOK_OUT, 7'h21, 1'b0, 1'b0, 1'b1, ANS_STALL);
    wr(REG_CSR, STL);
    // Short last packet, then one OUT too many
    setupRel(1'b0, 1'b1, 32'h0);
    tok(TOK_OUT, 7'($urandom_range(0, 31)), 1'b0, 1'b0, 1'b1, ANS_ACK);
    wr(REG_CSR, REL | DEND);
    tok(TOK_OUT, 7'h00, 1'b0, 1'b0, 1'b1, ANS_STALL);
    wr(REG_CSR, STL);
    // Wrong direction in each data stage, then a new setup inside one
    setupRel(1'b0, 1'b1, 32'h0);
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b0, ANS_ACK);
    rdChk(REG_CSR, 32'h310, 32'h010, "prematureEnd");
    wr(REG_CSR, PECLR);
    rdChk(REG_CSR, 32'h10, 32'h0, "premEndCleared");
    setupRel(1'b1, 1'b1, 32'h0);
    tok(TOK_OUT, 7'h00, 1'b0, 1'b0, 1'b0, ANS_ACK);
    rdChk(REG_CSR, 32'h310, 32'h010, "outInTx");
    wr(REG_CSR, PECLR);
    setupRel(1'b1, 1'b1, 32'h0);
    tok(TOK_SETUP, 7'h08, 1'b0, 1'b0, 1'b1, ANS_ACK);
    rdChk(REG_CSR, 32'h311, 32'h011, "setupInTx");
    wr(REG_CSR, PECLR | REL | DEND);
    zlNext = 1'b1;
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_DATA);
    zlNext = 1'b0;
    // Tokens with no transfer open
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_NAK);
    tok(TOK_OUT, 7'h00, 1'b0, 1'b0, 1'b1, ANS_STALL);
    wr(REG_CSR, STL);
    // Stall request in the data stage and in the status stage
    setupRel(1'b1, 1'b1, 32'h0);
    wr(REG_CSR, SNDS);
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_STALL);
    wr(REG_CSR, STL);
    setupRel(1'b0, 1'b0, DEND);
    wr(REG_CSR, SNDS);
    tok(TOK_IN, 7'h00, 1'b0, 1'b0, 1'b1, ANS_STALL);
    wr(REG_CSR, STL);
    // Masked event still sets the flag and leaves irq low
    wr(REG_MASK, 32'h0);
    wb(1'b0, REG_FLAGS, 32'h0, rdat);
    tok(TOK_SETUP, 7'h08, 1'b0, 1'b0, 1'b1, ANS_ACK);
    chk("irqMasked", 32'(irq), 32'h0);
    rdChk(REG_FLAGS, 32'h1, 32'h1, "flagMasked");
    // Disable clears the endpoint
    wr(REG_CTRL, 32'h0);
    rdChk(REG_CSR, 32'h3ff, 32'h0, "csrDisabled");
    chk("pendingAnswers", 32'(expQ.size()), 32'h0);
    test_done();
  end
endmodule // usb_control_endpoint_fsm_tb
